// *** test/aid_strap_model.sv ***
// Behavioural model of the address strapping, boot pin and drive fault source.
`timescale 1ns/100ps

module aid_strap_model
(
   input  wire logic [8:0] codes,
   input  wire logic       boot_req,
   input  wire logic       err_req,
   output logic      [7:0] addr_sel_pin_lo,
   output logic      [7:0] addr_sel_pin_mid,
   output logic      [7:0] addr_sel_pin_hi,
   output logic            boot_recovery_pin,
   output logic            fault_event
);
   // *****************************************************
   // Pin levels
   // *****************************************************
   // Mid-band samples keep each code well clear of the quantizer edges.
   localparam logic [7:0] LVL [8] = '{8'h00, 8'h50, 8'h85, 8'hab, 8'hc8, 8'hdf, 8'hf0, 8'hff};

   assign addr_sel_pin_lo   = LVL[codes[2:0]];
   assign addr_sel_pin_mid  = LVL[codes[5:3]];
   assign addr_sel_pin_hi   = LVL[codes[8:6]];
   // The pin is grounded only on a recovery request.
   assign boot_recovery_pin = !boot_req;
   assign fault_event       = err_req;
endmodule : aid_strap_model

// *** test/aid_top_checker.sv ***
// Concurrent checks on the ports of the axis address and indicator block.
`timescale 1ns/100ps

module aid_top_checker
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic [7:0]  addr_sel_pin_lo,
   input wire logic [7:0]  addr_sel_pin_mid,
   input wire logic [7:0]  addr_sel_pin_hi,
   input wire logic        boot_recovery_pin,
   input wire logic        fault_event,
   input wire logic        fault_indicator,
   input wire logic        ready_indicator,
   input wire logic        reprog_mode,
   input wire logic [8:0]  axis_address,
   input wire logic [15:0] station_alias
);
   logic [23:0] pins_r;
   logic [4:0]  stable_r;
   logic [8:0]  init_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   always_ff @(posedge aclk)
   begin
      pins_r <= {addr_sel_pin_hi, addr_sel_pin_mid, addr_sel_pin_lo};
   end

   // Saturating counts, so a long quiet spell never wraps back into range.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || pins_r != {addr_sel_pin_hi, addr_sel_pin_mid, addr_sel_pin_lo})
         stable_r <= 5'h0;
      else if (stable_r != 5'h1f)
         stable_r <= stable_r + 5'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || ready_indicator || fault_indicator || reprog_mode)
         init_r <= 9'h0;
      else if (ce && init_r != 9'h1ff)
         init_r <= init_r + 9'h1;
   end

   // *****************************************************
   // Assertions
   // *****************************************************
   bit8_zero_a: assert property (axis_address[8] == 1'b0)
      else $error("Axis address bit 8 is set.");
   alias_match_a: assert property (station_alias[15:9] == 7'h0 && (station_alias == 16'h0 ?
      axis_address == 9'h0ff : station_alias[8:0] == axis_address)) else $error("Station alias mismatch.");
   fault_on_a: assert property (ce && fault_event && boot_recovery_pin && !reprog_mode |=> fault_indicator)
      else $error("Fault indicator stayed dark.");
   fault_excl_a: assert property (fault_indicator |-> !ready_indicator)
      else $error("Ready lit together with fault.");
   ready_wait_a: assert property ($rose(ready_indicator) |-> init_r >= 9'd248)
      else $error("Ready lit before initialization time.");
   boot_enter_a: assert property (ce && !boot_recovery_pin |=> reprog_mode)
      else $error("Reprogramming mode not entered.");
   boot_dark_a: assert property (reprog_mode |-> !fault_indicator && !ready_indicator)
      else $error("Indicator lit in reprogramming mode.");
   addr_settle_a: assert property ($changed(axis_address) |-> stable_r >= 5'd9)
      else $error("Axis address moved before pins settled.");

   ready_up_c: cover property ($rose(ready_indicator));
   fault_up_c: cover property ($rose(fault_indicator));
   boot_up_c: cover property ($rose(reprog_mode));
   addr_chg_c: cover property ($changed(axis_address));
endmodule : aid_top_checker

bind aid_top aid_top_checker chk
(
   .aclk, .aresetn, .ce, .addr_sel_pin_lo, .addr_sel_pin_mid, .addr_sel_pin_hi, .boot_recovery_pin,
   .fault_event, .fault_indicator, .ready_indicator, .reprog_mode, .axis_address, .station_alias
);

// *** test/aid_top_test.sv ***
// Self-checking testbench of the axis address and indicator block.
`timescale 1ns/100ps
`include "aid_defs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t got %h exp %h", $time, g, e); end end

module aid_top_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] addr_sel_pin_lo, addr_sel_pin_mid, addr_sel_pin_hi;
   logic boot_recovery_pin, fault_event, fault_indicator, ready_indicator, reprog_mode;
   logic [8:0] axis_address;
   logic [15:0] station_alias;
   logic [8:0] codes = 9'h000;
   logic boot_req = 1'b0, err_req = 1'b0;
   int mismatches = 0, checks = 0;

   aid_strap_model strap (.codes, .boot_req, .err_req, .addr_sel_pin_lo, .addr_sel_pin_mid, .addr_sel_pin_hi,
      .boot_recovery_pin, .fault_event);
   aid_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_sel_pin_lo,
      .addr_sel_pin_mid, .addr_sel_pin_hi, .boot_recovery_pin, .fault_event, .fault_indicator, .ready_indicator,
      .reprog_mode, .axis_address, .station_alias, .irq);

   always #2 aclk = ~aclk;

   // *****************************************************
   // Bus tasks
   // *****************************************************
   // Checks follow a falling edge, so registered outputs have settled.
   task automatic wt(input int n);
      repeat (n) @(negedge aclk);
   endtask : wt

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw = 0, w = 0, b = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b)
      begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
   endtask : axw

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit ar = 0, b = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!b)
      begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid;
         if (b) `CHK(s_axi_rdata, e)
         if (b) `CHK(s_axi_rresp, er)
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (b) s_axi_rready <= 1'b0;
      end
   endtask : rdchk

   // *****************************************************
   // Scenarios
   // *****************************************************
   task automatic t_init;
      logic [1:0] r;
      `CHK(axis_address, 9'h0ff)
      `CHK(station_alias, 16'h0000)
      axw(`AID_OFS_CTRL, 32'h1, r);
      wt(2);
      `CHK(ready_indicator, 1'b0)
      wt(250);
      `CHK(ready_indicator, 1'b1)
      `CHK(fault_indicator, 1'b0)
   endtask : t_init

   task automatic t_addr;
      logic [2:0] c;
      logic [8:0] e;
      for (int i = 1; i < 9; i++)
      begin
         c = i[2:0];
         e = (c == 3'h0) ? 9'h0ff : {1'b0, c[1:0], c, c};
         @(posedge aclk);
         codes <= {c, c, c};
         wt(20);
         `CHK(axis_address, e)
         `CHK(axis_address[8], 1'b0)
         `CHK(station_alias, (c == 3'h0) ? 16'h0000 : {7'h0, e})
         rdchk(`AID_OFS_AXIS_ADDR, {23'h0, e}, `AID_RESP_OKAY);
      end
   endtask : t_addr

   task automatic t_fault;
      logic [1:0] r;
      axw(`AID_OFS_IRQ_MASK, 32'h1, r);
      @(posedge aclk);
      err_req <= 1'b1;
      wt(3);
      `CHK(fault_indicator, 1'b1)
      `CHK(ready_indicator, 1'b0)
      `CHK(irq, 1'b1)
      @(posedge aclk);
      err_req <= 1'b0;
      axw(`AID_OFS_IRQ_STAT, 32'hf, r);
      wt(3);
      `CHK(irq, 1'b0)
      `CHK(ready_indicator, 1'b0)
      axw(`AID_OFS_CTRL, 32'h5, r);
      wt(3);
      `CHK(fault_indicator, 1'b0)
      `CHK(ready_indicator, 1'b0)
      wt(255);
      `CHK(ready_indicator, 1'b1)
   endtask : t_fault

   task automatic t_boot;
      @(posedge aclk);
      boot_req <= 1'b1;
      err_req <= 1'b1;
      wt(3);
      `CHK(reprog_mode, 1'b1)
      `CHK(fault_indicator, 1'b0)
      `CHK(ready_indicator, 1'b0)
      @(posedge aclk);
      err_req <= 1'b0;
      @(posedge aclk);
      boot_req <= 1'b0;
      wt(3);
      `CHK(reprog_mode, 1'b0)
   endtask : t_boot

   task automatic t_bus;
      logic [1:0] r;
      rdchk(8'h18, 32'h0, `AID_RESP_SLVERR);
      axw(8'h18, 32'hffffffff, r);
      `CHK(r, `AID_RESP_SLVERR)
      axw(`AID_OFS_AXIS_ADDR, 32'h1aa, r);
      rdchk(`AID_OFS_AXIS_ADDR, 32'h0ff, `AID_RESP_OKAY);
   endtask : t_bus

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      wt(1);
      t_init();
      t_addr();
      t_fault();
      t_boot();
      t_bus();
      report_and_stop();
   end

   // Nearly seven times the expected run.
   initial
   begin
      repeat (5000) @(posedge aclk);
      mismatches++;
      report_and_stop();
   end
endmodule : aid_top_test

// *** verilog/aid_addr_field.sv ***
// Quantizer and settle filter for one address selection pin.
`timescale 1ns/100ps
`include "aid_defs.svh"

module aid_addr_field
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic [7:0] sample,
   output logic      [2:0] code,
   output logic            changed
);
   import aid_pkg::*;

   localparam logic [3:0] FILT_LAST = 4'(`AID_FILT_CYCLES - 1);

   logic [2:0] raw;
   logic [2:0] cand_r;
   logic [3:0] cnt_r;

   always_comb
   begin
      if (sample < `AID_THR_0)
         raw = 3'h0;
      else if (sample < `AID_THR_1)
         raw = 3'h1;
      else if (sample < `AID_THR_2)
         raw = 3'h2;
      else if (sample < `AID_THR_3)
         raw = 3'h3;
      else if (sample < `AID_THR_4)
         raw = 3'h4;
      else if (sample < `AID_THR_5)
         raw = 3'h5;
      else if (sample < `AID_THR_6)
         raw = 3'h6;
      else
         raw = 3'h7;
   end

   // A level near a threshold must settle before it moves the address.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cand_r  <= 3'h0;
         cnt_r   <= 4'h0;
         code    <= 3'h0;
         changed <= 1'b0;
      end
      else if (ce)
      begin
         changed <= 1'b0;
         if (raw != cand_r)
         begin
            cand_r <= raw;
            cnt_r  <= 4'h0;
         end
         else if (cnt_r != FILT_LAST)
            cnt_r <= cnt_r + 4'h1;
         else if (code != cand_r)
         begin
            code    <= cand_r;
            changed <= 1'b1;
         end
      end
   end

endmodule : aid_addr_field

// *** verilog/aid_axil_slave.sv ***
// AXI4-Lite slave front end that turns bus transfers into register accesses.
`timescale 1ns/100ps
`include "aid_defs.svh"

module aid_axil_slave
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output aid_pkg::aid_wreq_t wreq,
   input  wire logic          wr_err,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_err
);
   import aid_pkg::*;

   logic        aw_got_r;
   logic        w_got_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_now;
   logic        w_now;
   logic        do_wr;

   assign s_axi_awready = ce && !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready  = ce && !w_got_r && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;
   assign aw_now        = s_axi_awvalid && s_axi_awready;
   assign w_now         = s_axi_wvalid && s_axi_wready;
   assign do_wr         = (aw_got_r || aw_now) && (w_got_r || w_now);

   // ***************************************************************
   // Write channels
   // ***************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         wreq         <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AID_RESP_OKAY;
      end
      else if (ce)
      begin
         wreq.en <= 1'b0;
         // The address is held in the request, so the error decode sees it while W is awaited.
         if (aw_now)
            wreq.addr <= s_axi_awaddr;
         if (w_now)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            wreq.en      <= 1'b1;
            wreq.data    <= w_now ? s_axi_wdata : wdata_r;
            wreq.strb    <= w_now ? s_axi_wstrb : wstrb_r;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? `AID_RESP_SLVERR : `AID_RESP_OKAY;
         end
         else
         begin
            if (aw_now)
               aw_got_r <= 1'b1;
            if (w_now)
               w_got_r <= 1'b1;
            if (s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Read channels
   // ***************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `AID_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_err ? `AID_RESP_SLVERR : `AID_RESP_OKAY;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule : aid_axil_slave

// *** verilog/aid_defs.svh ***
// Constants of the axis address and status indicator block.
`ifndef AID_DEFS_SVH
`define AID_DEFS_SVH

// ***************************************************************
// Register byte offsets and field positions
// ***************************************************************
`define AID_OFS_AXIS_ADDR     8'h00
`define AID_OFS_STATION_ALIAS 8'h04
`define AID_OFS_CTRL          8'h08
`define AID_OFS_STATUS        8'h0c
`define AID_OFS_IRQ_STAT      8'h10
`define AID_OFS_IRQ_MASK      8'h14
`define AID_CTRL_INIT_DONE    0
`define AID_CTRL_SW_FAULT     1
`define AID_CTRL_FAULT_CLEAR  2
`define AID_EV_FAULT          0
`define AID_EV_READY          1
`define AID_EV_ADDR_CHANGE    2
`define AID_EV_BOOT           3
`define AID_EV_W              4

// ***************************************************************
// Reset values and fixed codes
// ***************************************************************
`define AID_CTRL_RST          2'h0
`define AID_IRQ_MASK_RST      4'h0
`define AID_ADDR_ALL_OPEN     9'h0ff
`define AID_ALIAS_ALL_OPEN    16'h0000
`define AID_RESP_OKAY         2'h0
`define AID_RESP_SLVERR       2'h2

// ***************************************************************
// Quantizer upper bounds of codes 0 to 6 on an 8-bit sample, and timing
// ***************************************************************
`define AID_THR_0             8'h29
`define AID_THR_1             8'h6d
`define AID_THR_2             8'h9b
`define AID_THR_3             8'hbc
`define AID_THR_4             8'hd4
`define AID_THR_5             8'he9
`define AID_THR_6             8'hf9
// Counts give 1 us of initialization and 40 ns of pin settling at the 4 ns clock.
`define AID_INIT_CYCLES       250
`define AID_FILT_CYCLES       10

`endif

// *** verilog/aid_pkg.sv ***
// Types shared by the axis address and status indicator block.
package aid_pkg;

   typedef enum logic [1:0]
   {
      AID_ST_INIT  = 2'b00,
      AID_ST_READY = 2'b01,
      AID_ST_FAULT = 2'b10,
      AID_ST_BOOT  = 2'b11
   } aid_state_t;

   typedef struct packed
   {
      logic        en;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } aid_wreq_t;

endpackage : aid_pkg

// *** verilog/aid_top.sv ***
// Axis address decoder with fault and ready indicators and boot recovery mode.
// Overview of operation
// - With every address pin open or grounded the axis address reads 255 and the station alias reads 0.
// - Bit 8 of the axis address is ignored and always reads as zero.
// - The fault indicator lights whenever an error condition is detected, except in reprogramming mode.
// - After reset the ready indicator stays dark until initialization completes and the init done bit of the control register is set, then lights.
// - The ready indicator goes dark as soon as an error occurs, so ready and fault never show together.
// - A grounded boot recovery pin puts the block in firmware reprogramming mode; the outside grounds it only for recovery.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "aid_defs.svh"

module aid_top
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  addr_sel_pin_lo,
   input  wire logic [7:0]  addr_sel_pin_mid,
   input  wire logic [7:0]  addr_sel_pin_hi,
   input  wire logic        boot_recovery_pin,
   input  wire logic        fault_event,
   output logic             fault_indicator,
   output logic             ready_indicator,
   output logic             reprog_mode,
   output logic [8:0]       axis_address,
   output logic [15:0]      station_alias,
   output logic             irq
);
   import aid_pkg::*;

   localparam logic [7:0] INIT_LAST = 8'(`AID_INIT_CYCLES - 1);

   aid_wreq_t            wreq;
   aid_state_t           state_r;
   aid_state_t           state_nxt;
   logic [2:0]           code_lo;
   logic [2:0]           code_mid;
   logic [2:0]           code_hi;
   logic [2:0]           code_chg;
   logic [7:0]           init_cnt_r;
   logic                 init_elapsed;
   logic [1:0]           ctrl_r;
   logic                 fault_clear;
   logic                 error_cond;
   logic [`AID_EV_W-1:0] irq_stat_r;
   logic [`AID_EV_W-1:0] irq_mask_r;
   logic [`AID_EV_W-1:0] ev_set;
   logic [`AID_EV_W-1:0] ev_clr;
   logic [8:0]           addr_nxt;
   logic [15:0]          alias_nxt;
   logic                 wr_hit;
   logic [31:0]          rd_data;
   logic                 rd_err;
   logic                 wr_err;

   // ***************************************************************
   // Register bus front end
   // ***************************************************************
   aid_axil_slave u_bus
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .ce            (ce),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wreq          (wreq),
      .wr_err        (wr_err),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   // ***************************************************************
   // Address pins
   // ***************************************************************
   aid_addr_field u_field_lo
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sample  (addr_sel_pin_lo),
      .code    (code_lo),
      .changed (code_chg[0])
   );

   aid_addr_field u_field_mid
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sample  (addr_sel_pin_mid),
      .code    (code_mid),
      .changed (code_chg[1])
   );

   aid_addr_field u_field_hi
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sample  (addr_sel_pin_hi),
      .code    (code_hi),
      .changed (code_chg[2])
   );

   always_comb
   begin
      if ((code_lo == 3'h0) && (code_mid == 3'h0) && (code_hi == 3'h0))
      begin
         addr_nxt  = `AID_ADDR_ALL_OPEN;
         alias_nxt = `AID_ALIAS_ALL_OPEN;
      end
      else
      begin
         // The top bit of the high pin code is dropped, so pin values 4 to 7 alias 0 to 3.
         addr_nxt  = {1'b0, code_hi[1:0], code_mid, code_lo};
         alias_nxt = {7'h00, addr_nxt};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         axis_address  <= `AID_ADDR_ALL_OPEN;
         station_alias <= `AID_ALIAS_ALL_OPEN;
      end
      else if (ce)
      begin
         axis_address  <= addr_nxt;
         station_alias <= alias_nxt;
      end
   end

   // ***************************************************************
   // Control register
   // ***************************************************************
   assign wr_hit      = wreq.en && wreq.strb[0];
   assign fault_clear = wr_hit && (wreq.addr == `AID_OFS_CTRL) && wreq.data[`AID_CTRL_FAULT_CLEAR];
   assign error_cond  = fault_event || ctrl_r[`AID_CTRL_SW_FAULT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_r <= `AID_CTRL_RST;
      else if (ce && wr_hit && (wreq.addr == `AID_OFS_CTRL))
         ctrl_r <= wreq.data[1:0];
   end

   // ***************************************************************
   // Indicator state machine
   // ***************************************************************
   // The settle counter restarts on every entry to initialization, so a
   // recovered fault or boot exit waits the full time again.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         init_cnt_r <= 8'h00;
      else if (ce)
      begin
         if (state_r != AID_ST_INIT)
            init_cnt_r <= 8'h00;
         else if (!init_elapsed)
            init_cnt_r <= init_cnt_r + 8'h01;
      end
   end

   assign init_elapsed = (init_cnt_r == INIT_LAST);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         AID_ST_INIT:
         begin
            if (error_cond)
               state_nxt = AID_ST_FAULT;
            else if (init_elapsed && ctrl_r[`AID_CTRL_INIT_DONE])
               state_nxt = AID_ST_READY;
         end
         AID_ST_READY:
         begin
            if (error_cond)
               state_nxt = AID_ST_FAULT;
         end
         AID_ST_FAULT:
         begin
            if (fault_clear && !error_cond)
               state_nxt = AID_ST_INIT;
         end
         AID_ST_BOOT:
         begin
            if (boot_recovery_pin)
               state_nxt = AID_ST_INIT;
         end
         default:
            state_nxt = AID_ST_INIT;
      endcase
      // The grounded recovery pin overrides every other condition.
      if (!boot_recovery_pin)
         state_nxt = AID_ST_BOOT;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r         <= AID_ST_INIT;
         fault_indicator <= 1'b0;
         ready_indicator <= 1'b0;
         reprog_mode     <= 1'b0;
      end
      else if (ce)
      begin
         state_r         <= state_nxt;
         fault_indicator <= (state_nxt == AID_ST_FAULT);
         ready_indicator <= (state_nxt == AID_ST_READY);
         reprog_mode     <= (state_nxt == AID_ST_BOOT);
      end
   end

   // ***************************************************************
   // Interrupt status and mask
   // ***************************************************************
   always_comb
   begin
      ev_set                      = '0;
      ev_set[`AID_EV_FAULT]       = (state_nxt == AID_ST_FAULT) && (state_r != AID_ST_FAULT);
      ev_set[`AID_EV_READY]       = (state_nxt == AID_ST_READY) && (state_r != AID_ST_READY);
      ev_set[`AID_EV_ADDR_CHANGE] = |code_chg;
      ev_set[`AID_EV_BOOT]        = (state_nxt == AID_ST_BOOT) && (state_r != AID_ST_BOOT);
      ev_clr                      = '0;
      if (wr_hit && (wreq.addr == `AID_OFS_IRQ_STAT))
         ev_clr = wreq.data[`AID_EV_W-1:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_r <= '0;
         irq_mask_r <= `AID_IRQ_MASK_RST;
         irq        <= 1'b0;
      end
      else if (ce)
      begin
         // A new event in the clearing cycle stays set.
         irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;
         if (wr_hit && (wreq.addr == `AID_OFS_IRQ_MASK))
            irq_mask_r <= wreq.data[`AID_EV_W-1:0];
         irq <= |(((irq_stat_r & ~ev_clr) | ev_set) & irq_mask_r);
      end
   end

   // ***************************************************************
   // Read decode
   // ***************************************************************
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (s_axi_araddr)
         `AID_OFS_AXIS_ADDR:     rd_data = {23'h000000, axis_address};
         `AID_OFS_STATION_ALIAS: rd_data = {16'h0000, station_alias};
         `AID_OFS_CTRL:          rd_data = {30'h00000000, ctrl_r};
         `AID_OFS_STATUS:        rd_data = {26'h0000000, !boot_recovery_pin, fault_event,
                                            reprog_mode, ready_indicator, fault_indicator, state_r == AID_ST_INIT};
         `AID_OFS_IRQ_STAT:      rd_data = {28'h0000000, irq_stat_r};
         `AID_OFS_IRQ_MASK:      rd_data = {28'h0000000, irq_mask_r};
         default:                rd_err  = 1'b1;
      endcase
   end

   always_comb
   begin
      case ((s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wreq.addr)
         `AID_OFS_AXIS_ADDR, `AID_OFS_STATION_ALIAS, `AID_OFS_CTRL,
         `AID_OFS_STATUS, `AID_OFS_IRQ_STAT, `AID_OFS_IRQ_MASK:
            wr_err = 1'b0;
         default:
            wr_err = 1'b1;
      endcase
   end

endmodule : aid_top

// *** verilog/aid_top_end.sv ***
// Holds no logic.
